// ### rtl/pma_pkg.sv
// Package for the PID math accelerator: register map, field layout, modes, widths
package pma_pkg;
   // Register indices (byte-wide registers, one per address)
   localparam logic [4:0] ADDR_CONFIG = 5'h00;
   localparam logic [4:0] ADDR_IN_H = 5'h01;
   localparam logic [4:0] ADDR_IN_L = 5'h02;
   localparam logic [4:0] ADDR_SET_H = 5'h03;
   localparam logic [4:0] ADDR_SET_L = 5'h04;
   localparam logic [4:0] ADDR_K1_H = 5'h05;
   localparam logic [4:0] ADDR_K1_L = 5'h06;
   localparam logic [4:0] ADDR_K2_H = 5'h07;
   localparam logic [4:0] ADDR_K2_L = 5'h08;
   localparam logic [4:0] ADDR_K3_H = 5'h09;
   localparam logic [4:0] ADDR_K3_L = 5'h0a;
   localparam logic [4:0] ADDR_OUT_0 = 5'h0b;
   localparam logic [4:0] ADDR_OUT_1 = 5'h0c;
   localparam logic [4:0] ADDR_OUT_2 = 5'h0d;
   localparam logic [4:0] ADDR_OUT_3 = 5'h0e;
   localparam logic [4:0] ADDR_OUT_4 = 5'h0f;
   localparam logic [4:0] ADDR_Z1_H = 5'h10;
   localparam logic [4:0] ADDR_Z1_L = 5'h11;
   localparam logic [4:0] ADDR_Z2_H = 5'h12;
   localparam logic [4:0] ADDR_Z2_L = 5'h13;
   localparam logic [4:0] ADDR_IRQ_FLAGS = 5'h14;
   localparam logic [4:0] ADDR_IRQ_ENABLES = 5'h15;
   // Config fields
   localparam int CFG_EN_BIT = 7;
   localparam int CFG_BUSY_BIT = 6;
   localparam logic [2:0] MODE_UNS_PLAIN = 3'h0;
   localparam logic [2:0] MODE_UNS_ACC = 3'h1;
   localparam logic [2:0] MODE_SGN_PLAIN = 3'h2;
   localparam logic [2:0] MODE_SGN_ACC = 3'h3;
   localparam logic [2:0] MODE_PID = 3'h5;
   // Flag and enable bit positions
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_OVF_BIT = 1;
   // Widths and reset values
   localparam int OUT_W = 35;
   localparam logic [34:0] OUT_RESET = 35'h0;
   localparam logic [15:0] WORD_RESET = 16'h0;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [1:0] STEP_LAST = 2'h2;
endpackage

// ### rtl/pma_accel.sv
// PID math accelerator: byte register port, PID and add-multiply datapath
`timescale 1ns/1ps
`default_nettype none

module pma_accel (
   input wire logic clk_sys, // System clock, 100 MHz
   input wire logic resetn, // Asynchronous reset, active low
   input wire logic [4:0] reg_addr, // Register index
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [7:0] reg_rdata, // Read data, cycle after strobe
   output logic busy, // Calculation in progress
   output logic done_irq, // Done interrupt request
   output logic overflow_irq // Overflow interrupt request
);

   typedef enum logic [1:0] {
      PMA_IDLE = 2'b00,
      PMA_CALC = 2'b01,
      PMA_DONE = 2'b11
   } pma_state_e;

   pma_state_e state;
   logic enable;
   logic [2:0] mode;
   logic [15:0] in_val, set_point, coef_current_error, coef_prev_error, coef_prev2_error;
   logic [15:0] error_history_one, error_history_two;
   logic [34:0] result_output;
   logic [1:0] step;
   logic [36:0] acc;
   logic [16:0] cur_error;
   logic done_irq_flag, overflow_irq_flag, done_irq_enable, overflow_irq_enable;
   logic start;
   logic [36:0] term;
   logic [36:0] next_acc;
   logic [34:0] next_out;
   logic ovf;

   // Low input byte write launches a calculation when enabled
   assign start = reg_wr && (reg_addr == pma_pkg::ADDR_IN_L) && enable;

   // Sequencer: three steps in PID mode, one in the add-multiply modes, one product each
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state <= PMA_IDLE;
         step <= 2'h0;
      end else begin
         unique case (state)
            PMA_IDLE: begin
               step <= 2'h0;
               if (start) begin
                  state <= PMA_CALC;
               end
            end
            PMA_CALC: begin
               if (mode != pma_pkg::MODE_PID || step == pma_pkg::STEP_LAST) begin
                  state <= PMA_DONE;
               end
               step <= step + 2'h1;
            end
            PMA_DONE: begin
               state <= PMA_IDLE;
            end
         endcase
      end
   end

   // Term of the current step; operands widened first so no product is cut short
   always_comb begin
      term = 37'h0;
      if (mode == pma_pkg::MODE_PID) begin
         unique case (step)
            2'h0: term = 37'(signed'(cur_error)) * 37'(signed'(coef_current_error));
            2'h1: term = 37'(signed'(error_history_one))
                         * 37'(signed'(coef_prev_error));
            default: term = 37'(signed'(error_history_two))
                            * 37'(signed'(coef_prev2_error));
         endcase
      end else if (mode[1]) begin
         // Signed: 17-bit sum keeps the carry of the addition
         term = 37'(signed'({in_val[15], in_val} + {set_point[15], set_point}))
                * 37'(signed'(coef_current_error));
      end else begin
         term = 37'({1'b0, in_val} + {1'b0, set_point}) * 37'(coef_current_error);
      end
   end

   assign next_acc = acc + term;

   // Final result: accumulate in PID and odd modes, wrap at output width
   always_comb begin
      logic [36:0] full;
      full = 37'h0;
      if (mode == pma_pkg::MODE_PID || mode == pma_pkg::MODE_SGN_ACC) begin
         full = acc + {{2{result_output[34]}}, result_output};
      end else if (mode[0]) begin
         // Unsigned accumulation: a set top output bit is magnitude, not sign
         full = acc + {2'h0, result_output};
      end else begin
         full = acc;
      end
      next_out = full[34:0];
      if (mode[1] || mode == pma_pkg::MODE_PID) begin
         ovf = (full[36:34] != {3{full[34]}});
      end else begin
         ovf = (full[36:35] != 2'h0);
      end
   end

   // Accumulator of the step products
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         acc <= 37'h0;
      end else if (state == PMA_IDLE) begin
         acc <= 37'h0;
      end else if (state == PMA_CALC) begin
         acc <= next_acc;
      end
   end

   // Configuration and operand registers, all software writable
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         enable <= 1'b0;
         mode <= 3'h0;
         in_val <= pma_pkg::WORD_RESET;
         set_point <= pma_pkg::WORD_RESET;
         coef_current_error <= pma_pkg::WORD_RESET;
         coef_prev_error <= pma_pkg::WORD_RESET;
         coef_prev2_error <= pma_pkg::WORD_RESET;
         done_irq_enable <= 1'b0;
         overflow_irq_enable <= 1'b0;
      end else if (reg_wr) begin
         unique case (reg_addr)
            pma_pkg::ADDR_CONFIG: begin
               enable <= reg_wdata[pma_pkg::CFG_EN_BIT];
               mode <= reg_wdata[2:0];
            end
            pma_pkg::ADDR_IN_H: in_val[15:8] <= reg_wdata;
            pma_pkg::ADDR_IN_L: in_val[7:0] <= reg_wdata;
            pma_pkg::ADDR_SET_H: set_point[15:8] <= reg_wdata;
            pma_pkg::ADDR_SET_L: set_point[7:0] <= reg_wdata;
            pma_pkg::ADDR_K1_H: coef_current_error[15:8] <= reg_wdata;
            pma_pkg::ADDR_K1_L: coef_current_error[7:0] <= reg_wdata;
            pma_pkg::ADDR_K2_H: coef_prev_error[15:8] <= reg_wdata;
            pma_pkg::ADDR_K2_L: coef_prev_error[7:0] <= reg_wdata;
            pma_pkg::ADDR_K3_H: coef_prev2_error[15:8] <= reg_wdata;
            pma_pkg::ADDR_K3_L: coef_prev2_error[7:0] <= reg_wdata;
            pma_pkg::ADDR_IRQ_ENABLES: begin
               done_irq_enable <= reg_wdata[pma_pkg::IRQ_DONE_BIT];
               overflow_irq_enable <= reg_wdata[pma_pkg::IRQ_OVF_BIT];
            end
            default: ;
         endcase
      end
   end

   // Current error latched at start from the new input byte
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cur_error <= 17'h0;
      end else if (start) begin
         cur_error <= {set_point[15], set_point} - {in_val[15], in_val[15:8], reg_wdata};
      end
   end

   // Output and error history: hardware update on finish (history in PID mode only), software restore otherwise
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         result_output <= pma_pkg::OUT_RESET;
         error_history_one <= pma_pkg::WORD_RESET;
         error_history_two <= pma_pkg::WORD_RESET;
      end else if (state == PMA_DONE) begin
         result_output <= next_out;
         if (mode == pma_pkg::MODE_PID) begin
            error_history_two <= error_history_one;
            error_history_one <= cur_error[15:0];
         end
      end else if (reg_wr) begin
         // Restore path; writes while busy corrupt the result, as documented
         unique case (reg_addr)
            pma_pkg::ADDR_OUT_0: result_output[7:0] <= reg_wdata;
            pma_pkg::ADDR_OUT_1: result_output[15:8] <= reg_wdata;
            pma_pkg::ADDR_OUT_2: result_output[23:16] <= reg_wdata;
            pma_pkg::ADDR_OUT_3: result_output[31:24] <= reg_wdata;
            pma_pkg::ADDR_OUT_4: result_output[34:32] <= reg_wdata[2:0];
            pma_pkg::ADDR_Z1_H: error_history_one[15:8] <= reg_wdata;
            pma_pkg::ADDR_Z1_L: error_history_one[7:0] <= reg_wdata;
            pma_pkg::ADDR_Z2_H: error_history_two[15:8] <= reg_wdata;
            pma_pkg::ADDR_Z2_L: error_history_two[7:0] <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Sticky flags: hardware set wins over a software clear in the same cycle
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         done_irq_flag <= 1'b0;
         overflow_irq_flag <= 1'b0;
      end else begin
         if (state == PMA_DONE) begin
            done_irq_flag <= 1'b1;
         end else if (reg_wr && reg_addr == pma_pkg::ADDR_IRQ_FLAGS) begin
            done_irq_flag <= reg_wdata[pma_pkg::IRQ_DONE_BIT];
         end
         if (state == PMA_DONE && ovf) begin
            overflow_irq_flag <= 1'b1;
         end else if (reg_wr && reg_addr == pma_pkg::ADDR_IRQ_FLAGS) begin
            overflow_irq_flag <= reg_wdata[pma_pkg::IRQ_OVF_BIT];
         end
      end
   end

   // Status outputs, registered; busy covers the whole calculation
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         busy <= 1'b0;
         done_irq <= 1'b0;
         overflow_irq <= 1'b0;
      end else begin
         busy <= start || (state == PMA_CALC);
         done_irq <= done_irq_flag && done_irq_enable;
         overflow_irq <= overflow_irq_flag && overflow_irq_enable;
      end
   end

   // Read data the cycle after the strobe; unmapped reads as zero
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= pma_pkg::BYTE_ZERO;
      end else if (reg_rd) begin
         unique case (reg_addr)
            pma_pkg::ADDR_CONFIG: reg_rdata <= {enable, busy, 3'h0, mode};
            pma_pkg::ADDR_IN_H: reg_rdata <= in_val[15:8];
            pma_pkg::ADDR_IN_L: reg_rdata <= in_val[7:0];
            pma_pkg::ADDR_SET_H: reg_rdata <= set_point[15:8];
            pma_pkg::ADDR_SET_L: reg_rdata <= set_point[7:0];
            pma_pkg::ADDR_K1_H: reg_rdata <= coef_current_error[15:8];
            pma_pkg::ADDR_K1_L: reg_rdata <= coef_current_error[7:0];
            pma_pkg::ADDR_K2_H: reg_rdata <= coef_prev_error[15:8];
            pma_pkg::ADDR_K2_L: reg_rdata <= coef_prev_error[7:0];
            pma_pkg::ADDR_K3_H: reg_rdata <= coef_prev2_error[15:8];
            pma_pkg::ADDR_K3_L: reg_rdata <= coef_prev2_error[7:0];
            pma_pkg::ADDR_OUT_0: reg_rdata <= result_output[7:0];
            pma_pkg::ADDR_OUT_1: reg_rdata <= result_output[15:8];
            pma_pkg::ADDR_OUT_2: reg_rdata <= result_output[23:16];
            pma_pkg::ADDR_OUT_3: reg_rdata <= result_output[31:24];
            pma_pkg::ADDR_OUT_4: reg_rdata <= {5'h0, result_output[34:32]};
            pma_pkg::ADDR_Z1_H: reg_rdata <= error_history_one[15:8];
            pma_pkg::ADDR_Z1_L: reg_rdata <= error_history_one[7:0];
            pma_pkg::ADDR_Z2_H: reg_rdata <= error_history_two[15:8];
            pma_pkg::ADDR_Z2_L: reg_rdata <= error_history_two[7:0];
            pma_pkg::ADDR_IRQ_FLAGS: reg_rdata <= {6'h0, overflow_irq_flag, done_irq_flag};
            pma_pkg::ADDR_IRQ_ENABLES: reg_rdata <= {6'h0, overflow_irq_enable, done_irq_enable};
            default: reg_rdata <= pma_pkg::BYTE_ZERO;
         endcase
      end else begin
         reg_rdata <= pma_pkg::BYTE_ZERO;
      end
   end

   // Checks: sequencing and busy; a calculation never outlives five cycles
   chk_busy_on_start: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      start |=> busy) else $error("busy not set after start");
   chk_busy_in_calc: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      (state == PMA_CALC) |=> busy) else $error("busy low during calculation");
   chk_busy_clears: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      (state == PMA_DONE && !start) |=> !busy) else $error("busy stuck after finish");
   chk_calc_bounded: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      start |-> ##[1:5] (state == PMA_DONE)) else $error("calculation too long");
   chk_pid_three_steps: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      (state == PMA_CALC && mode == pma_pkg::MODE_PID && step != pma_pkg::STEP_LAST) |=>
      (state == PMA_CALC)) else $error("controller step skipped");
   chk_addmul_one_step: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      (state == PMA_CALC && mode != pma_pkg::MODE_PID) |=>
      (state == PMA_DONE)) else $error("add-multiply not single step");
   chk_done_one_cycle: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      (state == PMA_DONE) |=> (state == PMA_IDLE)) else $error("finish state not left");

   // Checks: results and history; output must not move while a sum is built
   chk_out_steady: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      (state == PMA_CALC && !reg_wr) |=> $stable(result_output))
      else $error("output moved during calculation");
   chk_history_shift: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      (state == PMA_DONE && mode == pma_pkg::MODE_PID) |=>
      error_history_two == $past(error_history_one)) else $error("history not shifted");
   chk_history_one_load: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      (state == PMA_DONE && mode == pma_pkg::MODE_PID) |=>
      error_history_one == $past(cur_error[15:0])) else $error("history one not loaded");
   chk_plain_result: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      (state == PMA_DONE && mode == pma_pkg::MODE_UNS_PLAIN) |=>
      result_output == $past(acc[34:0])) else $error("plain result wrong");

   // Checks: flags and requests
   chk_done_sets_flag: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      (state == PMA_DONE) |=> done_irq_flag) else $error("done flag missing");
   chk_busy_falls_done: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      $fell(busy) |-> done_irq_flag) else $error("busy fell without done flag");
   chk_ovf_flag: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      (state == PMA_DONE && ovf) |=> overflow_irq_flag) else $error("overflow flag missing");
   chk_done_irq_gate: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      done_irq |-> $past(done_irq_enable)) else $error("done irq without enable");
   chk_ovf_irq_gate: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      overflow_irq |-> $past(overflow_irq_enable)) else $error("overflow irq without enable");

endmodule // pma_accel

`default_nettype wire

// ### sim/pma_accel_test.sv
// Self-checking testbench for the PID math accelerator
`timescale 1ns/1ps
`default_nettype none

module pma_accel_test;
   logic clk_sys;
   logic resetn;
   logic [4:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic busy;
   logic done_irq;
   logic overflow_irq;
   logic [7:0] rv;
   logic [34:0] m_out;
   logic [15:0] m_z1;
   logic [15:0] m_z2;
   int err_total;
   int num_checks;

   pma_accel dut (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .busy(busy),
      .done_irq(done_irq),
      .overflow_irq(overflow_irq)
   );

   // Free-running 100 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   // Bus cycles: strobe held one full cycle, released at the sampling edge
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask

   task automatic wr16(input logic [4:0] a, input logic [15:0] v);
      wr(a, v[15:8]);
      wr(a + 5'h01, v[7:0]);
   endtask

   task automatic wr_out(input logic [34:0] v);
      logic [39:0] t;
      t = {5'h00, v};
      for (int i = 0; i < 5; i++) wr(pma_pkg::ADDR_OUT_0 + 5'(i), t[8*i +: 8]);
      m_out = v;
   endtask

   // Reference arithmetic kept apart from the design; 37 bits hold any sum
   task automatic model(input logic [2:0] md, input logic [15:0] in, st, k1, k2, k3,
                        output logic ovf);
      logic signed [36:0] a;
      logic signed [36:0] s;
      logic signed [36:0] e;
      if (md == pma_pkg::MODE_PID) begin
         e = $signed(st) - $signed(in);
         s = e * $signed(k1) + $signed(m_z1) * $signed(k2) + $signed(m_z2) * $signed(k3)
             + $signed(m_out);
         m_z2 = m_z1;
         m_z1 = e[15:0];
         ovf = (s[36:34] != 3'b000) && (s[36:34] != 3'b111);
      end else if (md[1]) begin
         a = $signed(in) + $signed(st);
         s = a * $signed(k1) + (md[0] ? $signed(m_out) : 37'sd0);
         ovf = (s[36:34] != 3'b000) && (s[36:34] != 3'b111);
      end else begin
         a = {21'h0, in} + {21'h0, st};
         s = a * {21'h0, k1} + (md[0] ? {2'b00, m_out} : 37'h0);
         ovf = |s[36:35];
      end
      m_out = s[34:0];
   endtask

   // One full calculation in the documented order, then result and flags
   task automatic run(input logic [2:0] md, input logic [15:0] in, st, k1, k2, k3);
      logic [39:0] got;
      logic ovf;
      int n;
      wr(pma_pkg::ADDR_IRQ_FLAGS, 8'h00);
      wr(pma_pkg::ADDR_CONFIG, {5'h00, md});
      wr(pma_pkg::ADDR_CONFIG, {5'h10, md});
      wr16(pma_pkg::ADDR_K1_H, k1);
      wr16(pma_pkg::ADDR_K2_H, k2);
      wr16(pma_pkg::ADDR_K3_H, k3);
      wr16(pma_pkg::ADDR_SET_H, st);
      wr(pma_pkg::ADDR_IN_H, in[15:8]);
      wr(pma_pkg::ADDR_IN_L, in[7:0]);
      #1 check(busy, 1'b1);
      n = 0;
      while (busy !== 1'b0 && n < 20) begin
         @(posedge clk_sys);
         #1 n++;
      end
      check(n, (md == pma_pkg::MODE_PID) ? 4 : 2);
      model(md, in, st, k1, k2, k3, ovf);
      rd(pma_pkg::ADDR_IRQ_FLAGS);
      check(rv, {6'h00, ovf, 1'b1});
      got = '0;
      for (int i = 0; i < 5; i++) begin
         rd(pma_pkg::ADDR_OUT_0 + 5'(i));
         got[8*i +: 8] = rv;
      end
      check(got, {5'h00, m_out});
   endtask

   // Every register reads zero after reset; an unmapped write is dropped
   task automatic t_reset;
      for (int i = 0; i < 22; i++) begin
         rd(5'(i));
         check(rv, 8'h00);
      end
      wr(5'h1f, 8'h5a);
      rd(5'h1f);
      check(rv, 8'h00);
   endtask

   // Low input write without enable stores the byte but starts nothing
   task automatic t_noen;
      wr(pma_pkg::ADDR_IN_L, 8'h11);
      #1 check(busy, 1'b0);
      rd(pma_pkg::ADDR_IN_L);
      check(rv, 8'h11);
   endtask

   // All four add-multiply codes, carry out of the add, back-to-back accumulate
   task automatic t_addmul;
      run(pma_pkg::MODE_UNS_PLAIN, 16'hfff0, 16'h0020, 16'hffff, 16'h0, 16'h0);
      run(pma_pkg::MODE_UNS_ACC, 16'h1234, 16'h0001, 16'h0100, 16'h0, 16'h0);
      run(pma_pkg::MODE_UNS_ACC, 16'h8000, 16'h8000, 16'h0003, 16'h0, 16'h0);
      run(pma_pkg::MODE_SGN_PLAIN, 16'hfffe, 16'hfffd, 16'h0007, 16'h0, 16'h0);
      run(pma_pkg::MODE_SGN_ACC, 16'h8000, 16'h8000, 16'h8000, 16'h0, 16'h0);
   endtask

   // Restored state, then three controller steps and the shifted history
   task automatic t_pid;
      wr_out(35'h0_0000_0100);
      wr16(pma_pkg::ADDR_Z1_H, 16'h0010);
      wr16(pma_pkg::ADDR_Z2_H, 16'hfff0);
      m_z1 = 16'h0010;
      m_z2 = 16'hfff0;
      run(pma_pkg::MODE_PID, 16'h0100, 16'h0180, 16'h0003, 16'hfffe, 16'h0001);
      run(pma_pkg::MODE_PID, 16'h0200, 16'h0180, 16'h0005, 16'h0007, 16'hfffd);
      run(pma_pkg::MODE_PID, 16'h0150, 16'h0180, 16'hfff9, 16'h0011, 16'h0023);
      rd(pma_pkg::ADDR_Z1_H);
      check(rv, m_z1[15:8]);
      rd(pma_pkg::ADDR_Z1_L);
      check(rv, m_z1[7:0]);
      rd(pma_pkg::ADDR_Z2_H);
      check(rv, m_z2[15:8]);
      rd(pma_pkg::ADDR_Z2_L);
      check(rv, m_z2[7:0]);
   endtask

   // Wrap on overflow, and each request gated by its own enable
   task automatic t_ovf;
      wr(pma_pkg::ADDR_IRQ_ENABLES, 8'h02);
      wr_out(35'h7_ffff_ffff);
      run(pma_pkg::MODE_UNS_ACC, 16'h0001, 16'h0000, 16'h0001, 16'h0, 16'h0);
      check(overflow_irq, 1'b1);
      check(done_irq, 1'b0);
      wr(pma_pkg::ADDR_IRQ_ENABLES, 8'h01);
      repeat (2) @(posedge clk_sys);
      #1 check(done_irq, 1'b1);
      check(overflow_irq, 1'b0);
      wr(pma_pkg::ADDR_IRQ_FLAGS, 8'h00);
      repeat (2) @(posedge clk_sys);
      #1 check(done_irq, 1'b0);
      wr_out(35'h3_ffff_ffff);
      rd(pma_pkg::ADDR_OUT_4);
      check(rv, 8'h03);
      run(pma_pkg::MODE_SGN_ACC, 16'h0001, 16'h0000, 16'h0001, 16'h0, 16'h0);
   endtask

   task automatic close_out;
      $display("checks %0d, mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Main sequence: reset held six cycles, then the scenarios in turn
   initial begin
      resetn = 1'b0;
      reg_addr = 5'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      err_total = 0;
      num_checks = 0;
      m_out = '0;
      m_z1 = '0;
      m_z2 = '0;
      repeat (6) @(posedge clk_sys);
      resetn <= 1'b1;
      t_reset();
      t_noen();
      t_addmul();
      t_pid();
      t_ovf();
      close_out();
   end

   // Watchdog well beyond the few hundred cycles the scenarios need
   initial begin
      #200000;
      err_total++;
      close_out();
   end
endmodule // pma_accel_test

`default_nettype wire
